//--- rtl/pmdi_top.sv
/*
 pmdi_top: PHY-side data interface toward the MAC. Bytes from the PHY core
 pass an 8-word fifo and leave as MII nibbles, RMII dibits or SMII
 segments; MAC transmit bits are gathered into bytes. Straps pick the mode.
 Assumes link pins and straps are asynchronous to core_clk, and that the
 link clock is slow enough (400 ns) to be sampled by the 20 MHz core clock.
*/
// Added by the designer: the Avalon-MM register port and the placing of the registers.
// Summary of operation
// [R1] In MII mode the four receive lines follow the link clock and carry data only while the valid line is high.
// [R2] In RMII mode two receive bits are presented each link clock period in which the valid line is high.
// [R3] In SMII mode receive data goes out as 10-bit segments, repeated ten times per byte at 10 Mb/s.
// [R4] At 10 Mb/s the MAC may take any one of each ten repeated receive segments.
// [R5] In MII mode the transmit nibbles count as data only while transmit enable is high.
// [R6] In RMII mode two transmit bits are taken each link clock period in which transmit enable is high.
// [R7] In SMII mode the MAC sends 10-bit transmit segments, repeated ten times per byte at 10 Mb/s.
// [R8] At 10 Mb/s only one of each ten transmit segments is sampled for a byte.
// [R9] Fiber operation stays off while the fiber mode enable input is low.
// [R10] The chip reset must be held active for at least 50 microseconds.
// [R11] The autoneg strap level is latched into the autoneg enable bit at reset.
// [R12] RMII and SMII are chosen by their straps, sampled at reset.
// [R13] With neither strap high the interface runs plain MII.
`timescale 1ns/10ps
module pmdi_top
   import pmdi_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic link_clk,
   input wire logic autoneg_strap,
   input wire logic rmii_select_strap,
   input wire logic serial_iface_select_strap,
   input wire logic fiber_mode_enable,
   output logic [3:0] rxd,
   output logic rx_valid,
   output logic smii_sync,
   input wire logic [3:0] txd,
   input wire logic tx_en,
   input wire logic [7:0] rxb_data,
   input wire logic rxb_valid,
   output logic rxb_ready,
   output logic [7:0] txb_data,
   output logic txb_valid,
   output logic autoneg_enable_bit,
   output logic fiber_active,
   output logic [2:0] link_mode
);
   logic [PIN_W-1:0] sync_a_r, sync_b_r;
   logic lk_d_r, lk_rise, lk_fall, txen_s;
   logic [3:0] txd_s;
   pmdi_state_e st_r, st_nxt;
   pmdi_mode_e mode_r, mode_nxt;
   logic [3:0] strap_cnt_r, strap_cnt_nxt;
   logic aneg_r, aneg_nxt, spd10_r, spd10_nxt, fiber_r, fiber_nxt;
   logic run, ack_r, ack_nxt, wr_hit;
   logic [31:0] rdata_r, rdata_nxt;
   logic [9:0] rx_sh_r, rx_sh_nxt, rx_seg_r, rx_seg_nxt;
   logic [3:0] rx_cnt_r, rx_cnt_nxt, rx_rep_r, rx_rep_nxt;
   logic rx_act_r, rx_act_nxt, rx_valid_r, rx_valid_nxt;
   logic sync_r, sync_nxt;
   logic [3:0] rxd_r, rxd_nxt;
   logic fifo_valid, fifo_pop;
   logic [7:0] fifo_data;
   logic [9:0] tx_acc_r, tx_acc_nxt, tx_in;
   logic [3:0] tx_cnt_r, tx_cnt_nxt, tx_rep_r, tx_rep_nxt;
   logic [7:0] txb_data_r, txb_data_nxt;
   logic txb_valid_r, txb_valid_nxt, tx_emit;

   // byte steps per mode
   function automatic logic [3:0] mode_steps(input pmdi_mode_e m);
      unique case (m)
         PMDI_MII: mode_steps = MII_STEPS;
         PMDI_RMII: mode_steps = RMII_STEPS;
         default: mode_steps = SMII_SEG;
      endcase
   endfunction

   // active receive lanes per mode
   function automatic logic [3:0] lane_mask(input pmdi_mode_e m);
      unique case (m)
         PMDI_MII: lane_mask = 4'hF;
         PMDI_RMII: lane_mask = 4'h3;
         default: lane_mask = 4'h1;
      endcase
   endfunction

   // bits moved per link clock
   function automatic logic [3:0] lane_bits(input pmdi_mode_e m);
      unique case (m)
         PMDI_MII: lane_bits = 4'h4;
         PMDI_RMII: lane_bits = 4'h2;
         default: lane_bits = 4'h1;
      endcase
   endfunction

   // two-stage synchroniser for every link pin and strap; edges found from stage two
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         sync_a_r <= '0;
         sync_b_r <= '0;
         lk_d_r <= 1'b0;
      end else if (ce) begin
         sync_a_r <= {link_clk, tx_en, txd, autoneg_strap,
                      rmii_select_strap, serial_iface_select_strap,
                      fiber_mode_enable};
         sync_b_r <= sync_a_r;
         lk_d_r <= sync_b_r[PIN_LK];
      end
   end

   assign lk_rise = sync_b_r[PIN_LK] && !lk_d_r;
   assign lk_fall = !sync_b_r[PIN_LK] && lk_d_r;
   assign txen_s = sync_b_r[PIN_TXEN];
   assign txd_s = sync_b_r[PIN_TXD +: 4];
   assign run = (st_r == PMDI_ST_RUN);
   assign wr_hit = avs_write && ack_r && (avs_address == REG_CTRL);

   // strap capture waits for the synchroniser to fill after release
   always_comb begin
      st_nxt = st_r;
      strap_cnt_nxt = strap_cnt_r;
      mode_nxt = mode_r;
      aneg_nxt = aneg_r;
      spd10_nxt = spd10_r;
      fiber_nxt = sync_b_r[PIN_FEN]; // [R9]
      unique case (st_r)
         PMDI_ST_STRAP: begin
            strap_cnt_nxt = strap_cnt_r + 4'h1;
            if (strap_cnt_r == STRAP_WAIT) begin
               st_nxt = PMDI_ST_RUN;
               aneg_nxt = sync_b_r[PIN_ANEG]; // [R11]
               if (sync_b_r[PIN_SMII]) begin
                  mode_nxt = PMDI_SMII; // [R12]
               end else if (sync_b_r[PIN_RMII]) begin
                  mode_nxt = PMDI_RMII; // [R12]
               end else begin
                  mode_nxt = PMDI_MII; // [R13]
               end
            end
         end
         PMDI_ST_RUN: begin
            if (wr_hit) begin
               aneg_nxt = avs_writedata[CTRL_ANEG_BIT];
               spd10_nxt = avs_writedata[CTRL_SPD10_BIT];
            end
         end
         default: st_nxt = PMDI_ST_STRAP;
      endcase
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         st_r <= PMDI_ST_STRAP;
         strap_cnt_r <= 4'h0;
         mode_r <= PMDI_MII;
         aneg_r <= CTRL_ANEG_RST;
         spd10_r <= CTRL_SPD10_RST;
         fiber_r <= 1'b0;
      end else if (ce) begin
         st_r <= st_nxt;
         strap_cnt_r <= strap_cnt_nxt;
         mode_r <= mode_nxt;
         aneg_r <= aneg_nxt;
         spd10_r <= spd10_nxt;
         fiber_r <= fiber_nxt;
      end
   end

   // bus slave: one wait cycle, read data loaded while waiting
   always_comb begin
      ack_nxt = (avs_read || avs_write) && !ack_r;
      rdata_nxt = rdata_r;
      if (avs_read && !ack_r) begin
         rdata_nxt = 32'h0000_0000;
         if (avs_address == REG_CTRL) begin
            rdata_nxt[CTRL_ANEG_BIT] = aneg_r;
            rdata_nxt[CTRL_SPD10_BIT] = spd10_r;
         end else if (avs_address == REG_STAT) begin
            rdata_nxt[STAT_MODE_LSB +: 3] = mode_r;
            rdata_nxt[STAT_FIBER_BIT] = fiber_r;
            rdata_nxt[STAT_FIFO_NE_BIT] = fifo_valid;
            rdata_nxt[STAT_FIFO_RDY_BIT] = rxb_ready;
            rdata_nxt[STAT_RUN_BIT] = run;
         end
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         ack_r <= 1'b0;
         rdata_r <= 32'h0000_0000;
      end else if (ce) begin
         ack_r <= ack_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   assign avs_waitrequest = (avs_read || avs_write) && !ack_r;
   assign avs_readdata = rdata_r;

   // the link side drains the fifo only at its own pace, so it can fill
   pmdi_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_D)) u_fifo (
      .core_clk(core_clk),
      .rst(rst),
      .ce(ce),
      .in_valid(rxb_valid),
      .in_ready(rxb_ready),
      .in_data(rxb_data),
      .out_valid(fifo_valid),
      .out_ready(fifo_pop),
      .out_data(fifo_data)
   );

   // receive: new bits launched just after each link clock rise
   always_comb begin
      logic new_seg;
      new_seg = 1'b0;
      rx_sh_nxt = rx_sh_r;
      rx_seg_nxt = rx_seg_r;
      rx_cnt_nxt = rx_cnt_r;
      rx_rep_nxt = rx_rep_r;
      rx_act_nxt = rx_act_r;
      rx_valid_nxt = rx_valid_r;
      sync_nxt = sync_r;
      rxd_nxt = rxd_r;
      fifo_pop = 1'b0;
      if (!run) begin
         rx_act_nxt = 1'b0;
         rx_valid_nxt = 1'b0;
         sync_nxt = 1'b0;
         rxd_nxt = 4'h0;
         rx_cnt_nxt = 4'h0;
         rx_rep_nxt = 4'h0;
      end else if (lk_rise) begin
         if (rx_act_r && rx_cnt_r != mode_steps(mode_r) - 4'h1) begin
            rx_cnt_nxt = rx_cnt_r + 4'h1;
            rx_sh_nxt = rx_sh_r >> lane_bits(mode_r);
         end else if (mode_r == PMDI_SMII) begin
            // segments run without gaps; repeats reuse the held copy
            rx_cnt_nxt = 4'h0;
            rx_act_nxt = 1'b1;
            new_seg = !spd10_r || (rx_rep_r == 4'h0); // [R3]
            rx_rep_nxt = (spd10_r && rx_rep_r != SMII_REP - 4'h1) ?
                         rx_rep_r + 4'h1 : 4'h0;
            if (new_seg) begin
               fifo_pop = fifo_valid;
               rx_seg_nxt = fifo_valid ? {fifo_data, 2'b11} : 10'h000;
            end
            rx_sh_nxt = rx_seg_nxt;
         end else begin
            rx_cnt_nxt = 4'h0;
            fifo_pop = fifo_valid;
            rx_act_nxt = fifo_valid;
            rx_sh_nxt = {2'b00, fifo_data};
         end
         // lines are zero whenever no data is carried
         rx_valid_nxt = rx_act_nxt && (mode_r != PMDI_SMII); // [R1] [R2]
         sync_nxt = (mode_r == PMDI_SMII) && (rx_cnt_nxt == 4'h0);
         rxd_nxt = rx_act_nxt ? (rx_sh_nxt[3:0] & lane_mask(mode_r)) :
                   4'h0; // [R1] [R2]
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         rx_sh_r <= 10'h000;
         rx_seg_r <= 10'h000;
         rx_cnt_r <= 4'h0;
         rx_rep_r <= 4'h0;
         rx_act_r <= 1'b0;
         rx_valid_r <= 1'b0;
         sync_r <= 1'b0;
         rxd_r <= 4'h0;
      end else if (ce) begin
         rx_sh_r <= rx_sh_nxt;
         rx_seg_r <= rx_seg_nxt;
         rx_cnt_r <= rx_cnt_nxt;
         rx_rep_r <= rx_rep_nxt;
         rx_act_r <= rx_act_nxt;
         rx_valid_r <= rx_valid_nxt;
         sync_r <= sync_nxt;
         rxd_r <= rxd_nxt;
      end
   end

   // transmit: sampled at the link fall, mid-cell, clear of MAC updates
   always_comb begin
      logic [3:0] cur;
      cur = 4'h0;
      unique case (mode_r)
         PMDI_MII: tx_in = {txd_s, tx_acc_r[9:4]};
         PMDI_RMII: tx_in = {txd_s[1:0], tx_acc_r[9:2]};
         default: tx_in = {txd_s[0], tx_acc_r[9:1]};
      endcase
      tx_acc_nxt = tx_acc_r;
      tx_cnt_nxt = tx_cnt_r;
      tx_rep_nxt = tx_rep_r;
      tx_emit = 1'b0;
      if (!run) begin
         tx_cnt_nxt = 4'h0;
         tx_rep_nxt = 4'h0;
      end else if (lk_fall) begin
         if (mode_r == PMDI_SMII) begin
            // bit 0 is the cell in which our sync is high
            cur = sync_r ? 4'h0 : tx_cnt_r + 4'h1;
            tx_cnt_nxt = cur;
            tx_acc_nxt = tx_in;
            if (cur == SMII_SEG - 4'h1) begin
               tx_rep_nxt = (spd10_r && tx_rep_r != SMII_REP - 4'h1) ?
                            tx_rep_r + 4'h1 : 4'h0;
               tx_emit = tx_in[1] && (!spd10_r || tx_rep_r == 4'h0); // [R8]
            end
         end else if (txen_s) begin
            tx_acc_nxt = tx_in; // [R5] [R6]
            tx_emit = (tx_cnt_r == mode_steps(mode_r) - 4'h1);
            tx_cnt_nxt = tx_emit ? 4'h0 : tx_cnt_r + 4'h1;
         end else begin
            tx_cnt_nxt = 4'h0; // [R5] idle lines are ignored
         end
      end
      txb_valid_nxt = tx_emit;
      txb_data_nxt = tx_emit ? tx_in[9:2] : txb_data_r;
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         tx_acc_r <= 10'h000;
         tx_cnt_r <= 4'h0;
         tx_rep_r <= 4'h0;
         txb_data_r <= 8'h00;
         txb_valid_r <= 1'b0;
      end else if (ce) begin
         tx_acc_r <= tx_acc_nxt;
         tx_cnt_r <= tx_cnt_nxt;
         tx_rep_r <= tx_rep_nxt;
         txb_data_r <= txb_data_nxt;
         txb_valid_r <= txb_valid_nxt;
      end
   end

   assign rxd = rxd_r;
   assign rx_valid = rx_valid_r;
   assign smii_sync = sync_r;
   assign txb_data = txb_data_r;
   assign txb_valid = txb_valid_r;
   assign autoneg_enable_bit = aneg_r;
   assign fiber_active = fiber_r;
   assign link_mode = mode_r;

   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);

   mii_rx_idle_a: assert property ((mode_r == PMDI_MII) && !rx_valid_r
      |-> rxd_r == 4'h0) else $error("mii data moved while invalid"); // [R1]
   rmii_dibit_step_a: assert property (ce && run && lk_rise &&
      mode_r == PMDI_RMII && rx_act_r && rx_cnt_r != 4'h3 |=> rx_valid_r &&
      rx_cnt_r == $past(rx_cnt_r) + 4'h1 && rxd_r[3:2] == 2'b00)
      else $error("rmii dibit not presented"); // [R2]
   smii_seg_sync_a: assert property (ce && run && lk_rise &&
      mode_r == PMDI_SMII && rx_cnt_r == 4'h9 |=> sync_r)
      else $error("smii sync not every ten bits"); // [R3]
   smii_rx_repeat_a: assert property (fifo_pop && mode_r == PMDI_SMII &&
      spd10_r |-> rx_rep_r == 4'h0)
      else $error("smii byte taken mid repeat"); // [R3]
   mii_tx_gate_a: assert property (ce && tx_emit && mode_r == PMDI_MII
      |-> txen_s && tx_cnt_r == 4'h1 ##1 txb_valid_r)
      else $error("mii byte without enable"); // [R5]
   rmii_tx_gate_a: assert property (ce && tx_emit && mode_r == PMDI_RMII
      |-> txen_s && tx_cnt_r == 4'h3 ##1 txb_data_r == $past(tx_in[9:2]))
      else $error("rmii byte misassembled"); // [R6]
   smii_tx_once_a: assert property (tx_emit && mode_r == PMDI_SMII &&
      spd10_r |-> tx_rep_r == 4'h0)
      else $error("smii repeat sampled twice"); // [R8]
   fiber_off_a: assert property (ce && !sync_b_r[PIN_FEN] |=> !fiber_active)
      else $error("fiber on while disabled"); // [R9]
   aneg_latch_a: assert property (ce && st_r == PMDI_ST_STRAP &&
      st_nxt == PMDI_ST_RUN |=> aneg_r == $past(sync_b_r[PIN_ANEG]))
      else $error("autoneg strap not latched"); // [R11]
   mode_strap_a: assert property (ce && st_r == PMDI_ST_STRAP &&
      st_nxt == PMDI_ST_RUN |=> mode_r == ($past(sync_b_r[PIN_SMII]) ?
      PMDI_SMII : $past(sync_b_r[PIN_RMII]) ? PMDI_RMII : PMDI_MII))
      else $error("mode strap not latched"); // [R12] [R13]
endmodule

//--- rtl/pmdi_pkg.sv
/*
 pmdi_pkg: constants and types for the PHY-side data interface toward the
 MAC (MII / RMII / SMII), its strap capture and its Avalon-MM registers.
 Assumes a 20 MHz core clock and link pins sampled by that clock.
*/
package pmdi_pkg;
   // core clock
   localparam int CLK_HZ = 20_000_000;
   // chip reset high time the board must give, in microseconds
   localparam int RST_MIN_US = 50;
   localparam int RST_MIN_CYC = (RST_MIN_US * (CLK_HZ / 1_000_000));
   // cycles after reset release before straps are trusted
   localparam logic [3:0] STRAP_WAIT = 4'h3;
   // data fifo shape
   localparam int FIFO_W = 8;
   localparam int FIFO_D = 8;
   // link steps per byte and smii repetition
   localparam logic [3:0] MII_STEPS = 4'h2;
   localparam logic [3:0] RMII_STEPS = 4'h4;
   localparam logic [3:0] SMII_SEG = 4'hA;
   localparam logic [3:0] SMII_REP = 4'hA;
   // synchronised pin vector layout
   localparam int PIN_W = 10;
   localparam int PIN_LK = 9;
   localparam int PIN_TXEN = 8;
   localparam int PIN_TXD = 4;
   localparam int PIN_ANEG = 3;
   localparam int PIN_RMII = 2;
   localparam int PIN_SMII = 1;
   localparam int PIN_FEN = 0;
   // register byte offsets
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_STAT = 4'h4;
   // control register fields
   localparam int CTRL_ANEG_BIT = 12;
   localparam int CTRL_SPD10_BIT = 0;
   localparam logic CTRL_SPD10_RST = 1'b0;
   localparam logic CTRL_ANEG_RST = 1'b0;
   // status register fields
   localparam int STAT_MODE_LSB = 0;
   localparam int STAT_FIBER_BIT = 3;
   localparam int STAT_FIFO_NE_BIT = 4;
   localparam int STAT_FIFO_RDY_BIT = 5;
   localparam int STAT_RUN_BIT = 6;

   typedef enum logic [2:0] {
      PMDI_MII = 3'b001,
      PMDI_RMII = 3'b010,
      PMDI_SMII = 3'b100
   } pmdi_mode_e;

   typedef enum logic [1:0] {
      PMDI_ST_STRAP = 2'b01,
      PMDI_ST_RUN = 2'b10
   } pmdi_state_e;
endpackage

//--- rtl/pmdi_fifo.sv
/*
 pmdi_fifo: small synchronous fifo with valid/ready on both sides.
 Assumes DEPTH is a power of two and one clock domain.
*/
`timescale 1ns/10ps
module pmdi_fifo
   import pmdi_pkg::*;
#(
   parameter int WIDTH = FIFO_W,
   parameter int DEPTH = FIFO_D
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0] wr_r, wr_nxt, rd_r, rd_nxt;
   logic [AW:0] cnt_r, cnt_nxt;
   logic push, pop;

   // honest full and empty straight from the occupancy count
   assign in_ready = (cnt_r != (AW+1)'(DEPTH));
   assign out_valid = (cnt_r != '0);
   assign out_data = mem_r[rd_r];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   // pointer and count update
   always_comb begin
      wr_nxt = push ? wr_r + 1'b1 : wr_r;
      rd_nxt = pop ? rd_r + 1'b1 : rd_r;
      cnt_nxt = cnt_r;
      if (push && !pop) begin
         cnt_nxt = cnt_r + 1'b1;
      end else if (pop && !push) begin
         cnt_nxt = cnt_r - 1'b1;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         wr_r <= '0;
         rd_r <= '0;
         cnt_r <= '0;
      end else if (ce) begin
         wr_r <= wr_nxt;
         rd_r <= rd_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   // storage has no reset; only written words are ever read
   always_ff @(posedge core_clk) begin
      if (ce && push) begin
         mem_r[wr_r] <= in_data;
      end
   end
endmodule

//--- tb/pmdi_mac_model.sv
/*
 pmdi_mac_model: MAC-side partner for the PHY data interface.
 Assumes the bench calls its tasks and reads its receive queues.
*/
`timescale 1ns/10ps
module pmdi_mac_model (
   output logic link_clk,
   output logic [3:0] txd,
   output logic tx_en,
   input wire logic [3:0] rxd,
   input wire logic rx_valid,
   input wire logic smii_sync
);
   logic [3:0] nib_q[$];
   logic [9:0] seg_q[$];
   logic [9:0] seg;
   int n;

   // quiet transmit lines until a task drives them
   initial begin
      link_clk = 1'b0;
      txd = 4'h0;
      tx_en = 1'b0;
      n = 10;
   end

   // shared reference clock runs free, 400 ns
   always #200 link_clk = ~link_clk;

   // capture at the rise; nibbles count only while valid is high, segments only with bit 0 set
   always @(posedge link_clk) begin
      if (rx_valid === 1'b1) begin
         nib_q.push_back(rxd);
      end
      if (smii_sync === 1'b1) begin
         n = 0;
      end
      // every repeat is kept, so any one of ten may be used
      if (n < 10) begin
         seg[n] = rxd[0];
         n++;
         if (n == 10 && seg[0] === 1'b1) begin
            seg_q.push_back(seg);
         end
      end
   end

   // one link cell, changed just after a rising edge
   task automatic drive(input logic [3:0] v, input logic en);
      @(posedge link_clk);
      txd <= v;
      tx_en <= en;
   endtask

   // segments start in the sync cell and repeat back to back
   task automatic send_seg(input logic [9:0] s, input int reps);
      do @(posedge link_clk); while (smii_sync !== 1'b1);
      repeat (9) @(posedge link_clk);
      for (int r = 0; r < reps; r++) begin
         for (int i = 0; i < 10; i++) begin
            txd <= {3'h0, s[i]};
            @(posedge link_clk);
         end
      end
      txd <= 4'h0;
   endtask
endmodule

//--- tb/tb_top.sv
/*
 tb_top: self-checking bench for pmdi_top with the MAC partner model.
 Assumes the package constants and a free-running 400 ns link clock.
*/
`timescale 1ns/10ps
module tb_top
   import pmdi_pkg::*;
;
   logic core_clk, rst, ce, avs_read, avs_write, avs_waitrequest, link_clk;
   logic autoneg_strap, rmii_select_strap, serial_iface_select_strap;
   logic fiber_mode_enable, rx_valid, smii_sync, tx_en, rxb_valid;
   logic rxb_ready, txb_valid, autoneg_enable_bit, fiber_active, full_seen;
   logic [3:0] avs_address, rxd, txd;
   logic [31:0] avs_writedata, avs_readdata, rd;
   logic [7:0] rxb_data, txb_data, b;
   logic [2:0] link_mode;
   logic [7:0] tx_q[$];
   int bad_count, tests_run, cyc;

   pmdi_top dut (.core_clk, .rst, .ce, .avs_address, .avs_read, .avs_write,
      .avs_writedata, .avs_readdata, .avs_waitrequest, .link_clk,
      .autoneg_strap, .rmii_select_strap, .serial_iface_select_strap,
      .fiber_mode_enable, .rxd, .rx_valid, .smii_sync, .txd, .tx_en,
      .rxb_data, .rxb_valid, .rxb_ready, .txb_data, .txb_valid,
      .autoneg_enable_bit, .fiber_active, .link_mode);
   pmdi_mac_model mac (.link_clk, .txd, .tx_en, .rxd, .rx_valid, .smii_sync);

   always #25 core_clk = ~core_clk;

   // collect transmit bytes; the cycle ceiling cuts a hang short
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (txb_valid === 1'b1) begin
         tx_q.push_back(txb_data);
      end
      if (cyc == 60000) begin
         bad_count++;
         results();
      end
   end

   task automatic chk(input string nm, input logic [31:0] s, e);
      tests_run++;
      if (s !== e) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", nm, e, s);
      end
   endtask

   // one Avalon access, held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [3:0] a,
                      input logic [31:0] d);
      @(posedge core_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask

   // valid stays up across pushes; the caller drops it
   task automatic push(input logic [7:0] v);
      rxb_data <= v;
      rxb_valid <= 1'b1;
      do begin
         @(posedge core_clk);
         if (rxb_ready !== 1'b1) full_seen = 1'b1;
      end while (rxb_ready !== 1'b1);
   endtask

   task automatic wait_units(input int k);
      for (int i = 0; i < 4000 && mac.nib_q.size() + mac.seg_q.size() < k;
           i++) @(posedge core_clk);
   endtask

   // straps held steady well past release so the latch sees them
   task automatic reset_to(input logic an, rm, sm);
      @(posedge core_clk);
      rst <= 1'b1;
      autoneg_strap <= an;
      rmii_select_strap <= rm;
      serial_iface_select_strap <= sm;
      repeat (RST_MIN_CYC) @(posedge core_clk);
      rst <= 1'b0;
      repeat (10) @(posedge core_clk);
      mac.nib_q.delete();
      mac.seg_q.delete();
      tx_q.delete();
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   initial begin
      {core_clk, ce, rst} = 3'b011;
      {avs_read, avs_write, rxb_valid, full_seen} = 4'h0;
      {autoneg_strap, rmii_select_strap, serial_iface_select_strap} = 3'h0;
      fiber_mode_enable = 1'b0;
      avs_address = 4'h0;
      avs_writedata = 32'h0;
      rxb_data = 8'h00;
      {cyc, bad_count, tests_run} = 0;
      reset_to(1'b1, 1'b0, 1'b0);
      chk("mode", link_mode, PMDI_MII);
      chk("aneg", autoneg_enable_bit, 1'b1);
      chk("fiber", fiber_active, 1'b0);
      bus(1'b0, REG_CTRL, 32'h0);
      chk("ctrl", rd, 32'h0000_1000);
      bus(1'b1, REG_CTRL, 32'h0);
      bus(1'b0, REG_CTRL, 32'h0);
      chk("ctrl wr", rd, 32'h0);
      bus(1'b1, REG_STAT, 32'hFFFF_FFFF);
      bus(1'b0, REG_STAT, 32'h0);
      // fifo empty and ready, block running, fiber off, plain mii
      chk("stat", rd, 32'h0000_0061);
      bus(1'b0, 4'h8, 32'h0);
      chk("unmapped", rd, 32'h0);
      fiber_mode_enable <= 1'b1;
      repeat (6) @(posedge core_clk);
      chk("fiber on", fiber_active, 1'b1);
      fiber_mode_enable <= 1'b0;
      $display("test bus done");
      // ten bytes at core rate fill the eight-word fifo
      for (int i = 0; i < 10; i++) push(8'h5A + 8'(i * 19));
      rxb_valid <= 1'b0;
      wait_units(20);
      chk("full", full_seen, 1'b1);
      chk("mii cnt", mac.nib_q.size(), 20);
      for (int i = 0; i < 10; i++) begin
         b = 8'h5A + 8'(i * 19);
         chk("mii rx", {mac.nib_q[2*i+1], mac.nib_q[2*i]}, b);
      end
      repeat (40) @(posedge core_clk);
      chk("mii idle", {rx_valid, rxd}, 5'h00);
      mac.drive(4'h7, 1'b0);
      mac.drive(4'h5, 1'b1);
      mac.drive(4'hA, 1'b1);
      mac.drive(4'h3, 1'b1);
      mac.drive(4'hC, 1'b0);
      mac.drive(4'h9, 1'b0);
      repeat (40) @(posedge core_clk);
      chk("mii tx cnt", tx_q.size(), 1);
      chk("mii tx", tx_q[0], 8'hA5);
      $display("test mii done");
      reset_to(1'b0, 1'b1, 1'b0);
      chk("mode", link_mode, PMDI_RMII);
      chk("aneg", autoneg_enable_bit, 1'b0);
      push(8'hB4);
      rxb_valid <= 1'b0;
      wait_units(4);
      chk("rmii rx", {mac.nib_q[3][1:0], mac.nib_q[2][1:0], mac.nib_q[1][1:0],
         mac.nib_q[0][1:0]}, 8'hB4);
      mac.drive(4'hD, 1'b1);
      mac.drive(4'hE, 1'b1);
      mac.drive(4'h3, 1'b1);
      mac.drive(4'hC, 1'b1);
      // lines left low: smii reads txd[0] with no enable, so a high
      // leftover would look like a stream of enabled segments
      mac.drive(4'h0, 1'b0);
      repeat (40) @(posedge core_clk);
      chk("rmii tx cnt", tx_q.size(), 1);
      chk("rmii tx", tx_q[0], 8'h39);
      $display("test rmii done");
      reset_to(1'b1, 1'b0, 1'b1);
      chk("mode", link_mode, PMDI_SMII);
      push(8'h6B);
      rxb_valid <= 1'b0;
      wait_units(1);
      chk("smii rx", mac.seg_q[0], {8'h6B, 2'b11});
      bus(1'b1, REG_CTRL, 32'h0000_1001);
      mac.seg_q.delete();
      push(8'h81);
      rxb_valid <= 1'b0;
      wait_units(10);
      repeat (300) @(posedge core_clk);
      chk("smii10 cnt", mac.seg_q.size(), 10);
      for (int i = 0; i < 10; i++) begin
         chk("smii10 rx", mac.seg_q[i], {8'h81, 2'b11});
      end
      mac.send_seg({8'h5C, 2'b10}, 10);
      repeat (40) @(posedge core_clk);
      chk("smii10 tx cnt", tx_q.size(), 1);
      chk("smii10 tx", tx_q[0], 8'h5C);
      $display("test smii done");
      results();
   end
endmodule
